// [csr_pkg.sv]
/*
  Constants for the colour sensor I2C target: address, command codes,
  control field positions, integration periods and bus timeout.
  Assumes a 100 MHz system clock.
*/
`default_nettype none
package csr_pkg;
  localparam logic [6:0] TARGET_ADDR = 7'h10;
  localparam logic [7:0] CMD_CONTROL = 8'h00;
  localparam logic [7:0] CMD_RSVD_FIRST = 8'h01;
  localparam logic [7:0] CMD_RSVD_LAST = 8'h07;
  localparam logic [7:0] CMD_RED = 8'h08;
  localparam logic [7:0] CMD_GREEN = 8'h09;
  localparam logic [7:0] CMD_BLUE = 8'h0a;
  localparam logic [7:0] CMD_WHITE = 8'h0b;
  localparam int POS_POWER_DOWN = 0;
  localparam int POS_MANUAL = 1;
  localparam int POS_ONE_SHOT = 2;
  localparam int POS_IT_LO = 4;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h77;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int CLK_HZ = 100_000_000;
  localparam int BASE_IT_MS = 40;
  localparam int IT_MAX_CODE = 5;
  localparam int TIMEOUT_MS = 30;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int BASE_IT_CYCLES = BASE_IT_MS * (CLK_HZ / 1000);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_SKIP = 3'b101
  } csr_state_t;
endpackage
`default_nettype wire

// [csr_sensor.sv]
/*
  I2C target register interface and measurement sequencer of a four-channel
  colour sensor. Assumes scl and sda arrive asynchronously and are open drain;
  sample data comes from an external front end on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module csr_sensor #(
  parameter int TIMEOUT_CYC = csr_pkg::TIMEOUT_CYCLES,
  parameter int BASE_IT_CYC = csr_pkg::BASE_IT_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [15:0] red_sample,
  input wire logic [15:0] green_sample,
  input wire logic [15:0] blue_sample,
  input wire logic [15:0] white_sample,
  output logic integrating,
  output logic sensor_power_down,
  output logic [2:0] integration_time_select
);
  initial begin
    if (TIMEOUT_CYC < 2 || BASE_IT_CYC < 2) begin
      $error("csr_sensor: counts too small");
    end
  end

  // ****************************************************************
  // Pin synchronisers and condition detection
  // ****************************************************************
  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic scl_d_reg, sda_d_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end
  logic scl_s, sda_s, scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  // Oversampling at 100 MHz leaves over 100 samples per 400 kHz bit.
  assign start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // ****************************************************************
  // Stuck-low timeout
  // ****************************************************************
  logic [31:0] low_cnt_reg, low_cnt_next;
  logic bus_timeout;
  always_comb begin
    low_cnt_next = 32'h0000_0000;
    if (!scl_s || !sda_s) begin
      low_cnt_next = low_cnt_reg + 32'h0000_0001;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_cnt_reg <= 32'h0000_0000;
    end else begin
      low_cnt_reg <= low_cnt_next;
    end
  end
  assign bus_timeout = (low_cnt_reg >= 32'(TIMEOUT_CYC));

  // ****************************************************************
  // I2C target state machine
  // ****************************************************************
  csr_pkg::csr_state_t state_reg, state_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next, cmd_reg, cmd_next, low_reg, low_next;
  logic ack_reg, ack_next, hi_reg, hi_next;
  logic [15:0] control_reg, control_next, rd_word;
  logic [15:0] red_reg, green_reg, blue_reg, white_reg;
  logic oe_reg, oe_next, out_reg, out_next;
  logic done_pulse;

  always_comb begin
    case (cmd_reg)
      csr_pkg::CMD_CONTROL: rd_word = control_reg;
      csr_pkg::CMD_RED: rd_word = red_reg;
      csr_pkg::CMD_GREEN: rd_word = green_reg;
      csr_pkg::CMD_BLUE: rd_word = blue_reg;
      csr_pkg::CMD_WHITE: rd_word = white_reg;
      default: rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    cmd_next = cmd_reg;
    low_next = low_reg;
    ack_next = ack_reg;
    hi_next = hi_reg;
    oe_next = oe_reg;
    out_next = out_reg;
    control_next = control_reg;
    if (done_pulse) begin
      control_next[csr_pkg::POS_ONE_SHOT] = 1'b0;
    end
    if (bus_timeout || stop_cond) begin
      state_next = csr_pkg::ST_IDLE;
      oe_next = 1'b0;
    end else if (start_cond) begin
      // Repeated start keeps the command code for the read phase.
      state_next = csr_pkg::ST_ADDR;
      bit_next = 4'h0;
      ack_next = 1'b0;
      oe_next = 1'b0;
    end else if (scl_rise && !ack_reg && state_reg != csr_pkg::ST_RDATA) begin
      shift_next = {shift_reg[6:0], sda_s};
      bit_next = bit_reg + 4'h1;
    end else if (scl_rise && ack_reg && state_reg == csr_pkg::ST_RDATA) begin
      if (sda_s) begin
        state_next = csr_pkg::ST_SKIP;
      end
    end else if (scl_fall) begin
      if (ack_reg) begin
        ack_next = 1'b0;
        oe_next = 1'b0;
        bit_next = 4'h0;
        if (state_reg == csr_pkg::ST_RDATA) begin
          oe_next = 1'b1;
          out_next = hi_reg ? rd_word[15] : rd_word[7];
        end
      end else if (state_reg == csr_pkg::ST_RDATA) begin
        if (bit_reg == 4'h7) begin
          ack_next = 1'b1;
          oe_next = 1'b0;
          hi_next = 1'b1;
          bit_next = 4'h0;
        end else begin
          bit_next = bit_reg + 4'h1;
          out_next = hi_reg ? rd_word[4'd14 - bit_reg] : rd_word[4'd6 - bit_reg];
        end
      end else if (bit_reg == 4'h8) begin
        ack_next = 1'b1;
        case (state_reg)
          csr_pkg::ST_ADDR: begin
            if (shift_reg[7:1] == csr_pkg::TARGET_ADDR) begin
              oe_next = 1'b1;
              out_next = 1'b0;
              hi_next = 1'b0;
              state_next = shift_reg[0] ? csr_pkg::ST_RDATA : csr_pkg::ST_CMD;
            end else begin
              ack_next = 1'b0;
              state_next = csr_pkg::ST_SKIP;
            end
          end
          csr_pkg::ST_CMD: begin
            cmd_next = shift_reg;
            oe_next = 1'b1;
            out_next = 1'b0;
            hi_next = 1'b0;
            state_next = csr_pkg::ST_WDATA;
          end
          csr_pkg::ST_WDATA: begin
            oe_next = 1'b1;
            out_next = 1'b0;
            if (!hi_reg) begin
              low_next = shift_reg;
              hi_next = 1'b1;
            end else begin
              hi_next = 1'b0;
              // Word commits only after both bytes; results ignore writes.
              if (cmd_reg == csr_pkg::CMD_CONTROL) begin
                control_next = {8'h00, low_reg & csr_pkg::CTRL_WRITE_MASK};
              end
            end
          end
          default: begin
            ack_next = 1'b0;
            state_next = csr_pkg::ST_SKIP;
          end
        endcase
      end
    end
    if (state_reg == csr_pkg::ST_SKIP && !start_cond) begin
      oe_next = 1'b0;
      ack_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= csr_pkg::ST_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      low_reg <= 8'h00;
      ack_reg <= 1'b0;
      hi_reg <= 1'b0;
      oe_reg <= 1'b0;
      out_reg <= 1'b1;
      control_reg <= csr_pkg::CONTROL_RESET;
    end else begin
      state_reg <= state_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      cmd_reg <= cmd_next;
      low_reg <= low_next;
      ack_reg <= ack_next;
      hi_reg <= hi_next;
      oe_reg <= oe_next;
      out_reg <= out_next;
      control_reg <= control_next;
    end
  end
  // Open drain: only ever pull low.
  assign sda_oe = oe_reg && !out_reg;
  assign sda_out = 1'b0;

  // ****************************************************************
  // Measurement sequencer
  // ****************************************************************
  logic [31:0] it_cnt_reg, it_cnt_next, it_len;
  logic run_reg, run_next;
  logic [2:0] it_sel;
  logic pd, manual, one_shot_request;
  assign pd = control_reg[csr_pkg::POS_POWER_DOWN];
  assign manual = control_reg[csr_pkg::POS_MANUAL];
  assign one_shot_request = control_reg[csr_pkg::POS_ONE_SHOT];
  assign it_sel = control_reg[csr_pkg::POS_IT_LO +: 3];
  // Codes above 101 have no defined period; they fall back to the longest.
  assign it_len = 32'(BASE_IT_CYC) << ((it_sel > 3'(csr_pkg::IT_MAX_CODE)) ?
                  3'(csr_pkg::IT_MAX_CODE) : it_sel);

  always_comb begin
    it_cnt_next = it_cnt_reg;
    run_next = run_reg;
    done_pulse = 1'b0;
    if (pd) begin
      run_next = 1'b0;
      it_cnt_next = 32'h0000_0000;
    end else if (!run_reg) begin
      // Manual mode runs once per request; automatic mode runs freely.
      if (!manual || one_shot_request) begin
        run_next = 1'b1;
        it_cnt_next = 32'h0000_0000;
      end
    end else if (it_cnt_reg + 32'h0000_0001 >= it_len) begin
      done_pulse = 1'b1;
      run_next = 1'b0;
      it_cnt_next = 32'h0000_0000;
    end else begin
      it_cnt_next = it_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      it_cnt_reg <= 32'h0000_0000;
      run_reg <= 1'b0;
      red_reg <= csr_pkg::RESULT_RESET;
      green_reg <= csr_pkg::RESULT_RESET;
      blue_reg <= csr_pkg::RESULT_RESET;
      white_reg <= csr_pkg::RESULT_RESET;
    end else begin
      it_cnt_reg <= it_cnt_next;
      run_reg <= run_next;
      if (done_pulse) begin
        red_reg <= red_sample;
        green_reg <= green_sample;
        blue_reg <= blue_sample;
        white_reg <= white_sample;
      end
    end
  end
  assign integrating = run_reg;
  assign sensor_power_down = pd;
  assign integration_time_select = it_sel;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_results_hold: assert property (@(posedge clk) disable iff (reset)
    !done_pulse |=> $stable(red_reg) && $stable(white_reg))
    else $error("result changed without measurement");
  a_shutdown_idle: assert property (@(posedge clk) disable iff (reset)
    pd |=> !run_reg)
    else $error("running while shut down");
  a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
    control_reg[15:8] == 8'h00 && !control_reg[7] && !control_reg[3])
    else $error("reserved control bit set");
  a_one_shot_request_clears: assert property (@(posedge clk) disable iff (reset)
    done_pulse && !(scl_fall && !ack_reg && state_reg == csr_pkg::ST_WDATA) |=> !one_shot_request)
    else $error("one shot did not clear");
  a_manual_wait: assert property (@(posedge clk) disable iff (reset)
    !run_reg && manual && !one_shot_request && !pd |=> !run_reg)
    else $error("manual mode ran without request");
  a_auto_start: assert property (@(posedge clk) disable iff (reset)
    !run_reg && !manual && !pd |=> run_reg)
    else $error("auto mode failed to restart");
  a_timeout_idle: assert property (@(posedge clk) disable iff (reset)
    bus_timeout |=> state_reg == csr_pkg::ST_IDLE && !sda_oe)
    else $error("timeout did not reset bus");
  a_only_low: assert property (@(posedge clk) disable iff (reset)
    sda_oe |-> !sda_out)
    else $error("sda driven high");
endmodule
`default_nettype wire

// [csr_host.sv]
/*
  Behavioural I2C host that talks to the colour sensor target.
  Assumes sda is open drain with a pull-up that is resolved outside this model.
*/
`timescale 1ns/1ns
`default_nettype none
module csr_host (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // ************************************************************
  // Bus cycles
  // ************************************************************
  // Scl stands high between frames. Sda moves 45 ns after the scl fall, so a
  // synchronised target never mistakes a data change for a start or a stop.
  initial begin
    scl = 1'h1;
    sda_pull = 1'h0;
  end
  task automatic bit_io(input logic b, output logic r);
    #45 sda_pull = ~b;
    #18 scl = 1'h1;
    #31 r = sda;
    #31 scl = 1'h0;
  endtask
  task automatic start_c();
    #45 sda_pull = 1'h0;
    #18 scl = 1'h1;
    #60 sda_pull = 1'h1;
    #60 scl = 1'h0;
  endtask
  task automatic stop_c();
    #45 sda_pull = 1'h1;
    #18 scl = 1'h1;
    #60 sda_pull = 1'h0;
    #60;
  endtask
  task automatic tx(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'h1, r);
    ok = ok & ~r;
  endtask
  task automatic rx(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] cmd, input logic [15:0] d,
                        output logic ok);
    ok = 1'h1;
    start_c();
    tx({a, 1'h0}, ok);
    tx(cmd, ok);
    tx(d[7:0], ok);
    tx(d[15:8], ok);
    stop_c();
  endtask
  task automatic rd_reg(input logic [7:0] cmd, output logic [15:0] d);
    logic ok;
    ok = 1'h1;
    start_c();
    tx({csr_pkg::TARGET_ADDR, 1'h0}, ok);
    tx(cmd, ok);
    start_c();
    tx({csr_pkg::TARGET_ADDR, 1'h1}, ok);
    rx(1'h1, d[7:0]);
    rx(1'h0, d[15:8]);
    stop_c();
  endtask
  // Stops with scl high in the ack slot of an address byte.
  task automatic stall();
    logic r;
    start_c();
    for (int i = 7; i >= 0; i--) begin
      bit_io(csr_pkg::TARGET_ADDR[(i + 6) % 7] & (i != 0), r);
    end
    #45 sda_pull = 1'h0;
    #18 scl = 1'h1;
  endtask
  task automatic resume();
    #100 scl = 1'h0;
  endtask
endmodule
`default_nettype wire

// [csr_sensor_bench.sv]
/*
  Self-checking bench for the colour sensor register interface.
  Assumes the csr_host model drives the bus; sample ports come from here.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module csr_sensor_bench;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic scl, host_pull, sda, sda_oe, sda_out, integrating, pd, ok;
  logic int_d = 1'h0;
  logic [2:0] its;
  logic [15:0] d;
  logic [15:0] smp [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  int n_errors = 0;
  int tests_run = 0;
  int rises = 0;
  int base;
  assign sda = ~(host_pull | sda_oe);
  csr_sensor #(.TIMEOUT_CYC(5000), .BASE_IT_CYC(50)) dut (.clk(clk), .reset(reset),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .red_sample(smp[0]), .green_sample(smp[1]), .blue_sample(smp[2]),
    .white_sample(smp[3]), .integrating(integrating), .sensor_power_down(pd),
    .integration_time_select(its));
  csr_host host (.scl(scl), .sda_pull(host_pull), .sda(sda));
  // ************************************************************
  // Helpers
  // ************************************************************
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    int_d <= integrating;
    if (integrating && !int_d) rises <= rises + 1;
  end
  function automatic logic [15:0] sv(input logic [15:0] b, input int i);
    return b + 16'h1357 * i[15:0];
  endfunction
  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    host.rd_reg(cmd, d);
    `CHK("read data", exp, d)
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] v);
    host.wr_reg(csr_pkg::TARGET_ADDR, cmd, v, ok);
    `CHK("write ack", 1'h1, ok)
  endtask
  task automatic set_smp(input logic [15:0] b);
    @(negedge clk);
    for (int i = 0; i < 4; i++) smp[i] = sv(b, i);
  endtask
  // ************************************************************
  // Tests
  // ************************************************************
  // The watchdog allows over twice the expected run of some 27500 cycles.
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (2) @(negedge clk);
    reset = 1'h0;
    repeat (4) @(negedge clk);
    `CHK("integrating", 1'h1, integrating)
    rd(8'h00, 16'h0000);
    for (int c = 5; c >= 0; c--) begin
      wr(8'h00, {9'h000, c[2:0], 4'h0});
      `CHK("it select", c[2:0], its)
      rd(8'h00, {9'h000, c[2:0], 4'h0});
    end
    set_smp(16'hFF00);
    repeat (300) @(posedge clk);
    for (int c = 0; c < 4; c++) rd(8'h08 + c[7:0], sv(16'hFF00, c));
    wr(8'h08, 16'h1234);
    rd(8'h08, sv(16'hFF00, 0));
    for (int c = 1; c < 8; c++) rd(c[7:0], 16'h0000);
    host.wr_reg(7'h11, 8'h00, 16'h0002, ok);
    `CHK("foreign ack", 1'h0, ok)
    wr(8'h00, 16'h0002);
    repeat (300) @(posedge clk);
    set_smp(16'h00FF);
    repeat (300) @(posedge clk);
    rd(8'h0b, sv(16'hFF00, 3));
    base = rises;
    wr(8'h00, 16'h0006);
    repeat (300) @(posedge clk);
    `CHK("cycles", base + 1, rises)
    rd(8'h0b, sv(16'h00FF, 3));
    rd(8'h00, 16'h0002);
    wr(8'h00, 16'hFF89);
    `CHK("power down", 1'h1, pd)
    rd(8'h00, 16'h0001);
    set_smp(16'hA5A5);
    repeat (300) @(posedge clk);
    rd(8'h09, sv(16'h00FF, 1));
    // A target left pulling sda would hang the bus until the low timeout frees it.
    host.stall();
    repeat (20) @(posedge clk);
    `CHK("ack hold", 1'h1, sda_oe)
    repeat (5100) @(posedge clk);
    `CHK("bus timeout", 1'h0, sda_oe)
    host.resume();
    rd(8'h00, 16'h0001);
    stop_test();
  end
endmodule
`default_nettype wire
